// ==== logic/cno_nmt_node.sv ====
// How it works
// - power-up enters initialization unprompted
// - reset app then reset comm, automatic
// - then pre-operational plus one boot-up
// - command: id 0, cs, node (0=all)
// - 01 op, 02 stop, 80 pre-op
// - 81 app reset, 82 comm reset
// - execute commands, never acknowledge them
// - services gated by node state
// - heartbeat only, no node guarding
// - producer sends heartbeat every period
// - consumer flags loss after timeout
// - sync mode defers commands until sync
// - fault: send emergency, enter error
// - fault cleared: emergency code 0, normal
// - emergency 80h+node, code, errreg, maker
// - error register 0, 1, 80h
// - 11-bit ids, broadcast function codes
// - process data bases plus node
// - sdo and heartbeat bases plus node
`timescale 1ns/1ps
`default_nettype none
module cno_nmt_node
   import cno_pkg::*;
#(
   parameter int TICK_CYC = CNO_TICK_CYC
) (
   input  wire logic        clk,         // core clock
   input  wire logic        rst,         // sync reset, power-up
   input  wire logic [6:0]  node_id,     // own node address
   input  wire logic        rx_valid,    // received frame strobe
   input  wire logic [10:0] rx_id,       // received identifier
   input  wire logic [3:0]  rx_dlc,      // received length
   input  wire logic [7:0]  rx_b0,       // received byte 0
   input  wire logic [7:0]  rx_b1,       // received byte 1
   input  wire logic        app_done,    // application reset finished
   input  wire logic        comm_done,   // communication reset finished
   input  wire logic        sync_mode,   // defer commands to sync
   input  wire logic [15:0] hb_prod_ms,  // producer period, 0 off
   input  wire logic [15:0] hb_cons_ms,  // consumer timeout, 0 off
   input  wire logic [6:0]  hb_cons_node,// monitored producer
   input  wire logic        fault,       // internal fault level
   input  wire logic        fault_dev,   // fault is device-internal
   input  wire logic [15:0] fault_code,  // emergency code
   input  wire logic [39:0] fault_maker, // maker-defined code
   input  wire logic        tx_ready,    // transmitter accepts frame
   output logic             tx_valid,    // frame offered
   output logic [10:0]      tx_id,       // frame identifier
   output logic [3:0]       tx_dlc,      // frame length
   output logic [63:0]      tx_data,     // byte 0 in low bits
   output cno_state_t       state,       // node state
   output logic             pdo_en,      // process data allowed
   output logic             sdo_en,      // service data allowed
   output logic             sync_en,     // sync allowed
   output logic             time_en,     // time stamp allowed
   output logic             emcy_en,     // emergency allowed
   output logic             boot_en,     // boot-up allowed
   output logic             nmt_en,      // node control allowed
   output logic             sync_pulse,  // sync received, actuate
   output logic             app_rst_req, // application reset running
   output logic             comm_rst_req,// communication reset running
   output logic             in_error,    // error state
   output logic [7:0]       err_reg,     // dictionary 1001h
   output logic             hb_lost,     // consumer lost producer
   output logic [10:0]      cob_tpdo1,   // tx pdo 1 identifier
   output logic [10:0]      cob_rpdo1,   // rx pdo 1 identifier
   output logic [10:0]      cob_sdo_tx,  // sdo reply identifier
   output logic [10:0]      cob_sdo_rx   // sdo request identifier
);
   logic       tick;
   logic       cmd_hit;
   logic       cmd_ok;
   logic       pend;
   logic [7:0] pend_cs;
   logic       do_cmd;
   logic [7:0] do_cs;
   logic       boot_pend;
   logic       emcy_pend;
   logic       emcy_is_clear;
   logic       hb_pend;
   logic [15:0] hb_age;
   logic       hb_rx;
   logic       fault_q;
   cno_state_t next_state;
   logic       tx_fire;

   cno_ms_tick #(.TICK_CYC(TICK_CYC)) u_tick (
      .clk  (clk),
      .rst  (rst),
      .tick (tick)
   );

   assign hb_rx = rx_valid && rx_id == cno_cob(CNO_FC_HB, hb_cons_node);

   cno_hb_consumer u_hbc (
      .clk        (clk),
      .rst        (rst),
      .tick       (tick),
      .timeout_ms (hb_cons_ms),
      .hb_seen    (hb_rx),
      .lost       (hb_lost)
   );

   always_comb begin
      pdo_en  = state == CNO_OP;
      sdo_en  = state == CNO_OP || state == CNO_PREOP;
      sync_en = sdo_en;
      time_en = sdo_en;
      emcy_en = sdo_en;
      boot_en = state == CNO_RST_APP || state == CNO_RST_COMM;
      nmt_en  = sdo_en || state == CNO_STOP;
   end

   assign cmd_hit = rx_valid && rx_id == CNO_ID_NMT && rx_dlc == CNO_NMT_DLC && nmt_en
                    && (rx_b1[6:0] == node_id || rx_b1[6:0] == CNO_NODE_BCAST) && !rx_b1[7];
   assign cmd_ok  = rx_b0 == CNO_CS_START || rx_b0 == CNO_CS_STOP || rx_b0 == CNO_CS_PREOP
                    || rx_b0 == CNO_CS_RST_APP || rx_b0 == CNO_CS_RST_COM;

   assign sync_pulse = rx_valid && rx_id == CNO_ID_SYNC && sync_en;

   always_ff @(posedge clk) begin
      if (rst || !nmt_en) begin
         pend    <= 1'b0;
         pend_cs <= CNO_CS_PREOP;
      end else if (cmd_hit && cmd_ok && sync_mode) begin
         pend    <= 1'b1;
         pend_cs <= rx_b0;
      end else if (sync_pulse || !sync_mode) begin
         pend    <= 1'b0;
      end
   end

   always_comb begin
      do_cmd = 1'b0;
      do_cs  = rx_b0;
      if (cmd_hit && cmd_ok && !sync_mode) begin
         do_cmd = 1'b1;
      end else if (pend && sync_pulse) begin
         do_cmd = 1'b1;
         do_cs  = pend_cs;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         CNO_RST_APP:  if (app_done) next_state = CNO_RST_COMM;
         CNO_RST_COMM: if (comm_done) next_state = CNO_PREOP;
         CNO_PREOP, CNO_OP, CNO_STOP: begin
            if (do_cmd) begin
               case (do_cs)
                  CNO_CS_START:   next_state = CNO_OP;
                  CNO_CS_STOP:    next_state = CNO_STOP;
                  CNO_CS_PREOP:   next_state = CNO_PREOP;
                  CNO_CS_RST_APP: next_state = CNO_RST_APP;
                  CNO_CS_RST_COM: next_state = CNO_RST_COMM;
                  default:        next_state = state;
               endcase
            end
         end
         default: next_state = CNO_RST_APP;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= CNO_RST_APP;
      end else begin
         state <= next_state;
      end
   end

   assign app_rst_req  = state == CNO_RST_APP;
   assign comm_rst_req = state == CNO_RST_COMM;

   always_ff @(posedge clk) begin
      if (rst) begin
         fault_q  <= 1'b0;
         in_error <= 1'b0;
         err_reg  <= CNO_ER_NONE;
      end else begin
         fault_q <= fault;
         if (fault && !fault_q) begin
            in_error <= 1'b1;
            err_reg  <= fault_dev ? CNO_ER_DEVICE : CNO_ER_GENERIC;
         end else if (!fault && fault_q) begin
            in_error <= 1'b0;
            err_reg  <= CNO_ER_NONE;
         end
      end
   end

   // emergency requests; edge wins over send
   always_ff @(posedge clk) begin
      if (rst) begin
         emcy_pend     <= 1'b0;
         emcy_is_clear <= 1'b0;
      end else if (fault != fault_q) begin
         emcy_pend     <= 1'b1;
         emcy_is_clear <= !fault;
      end else if (tx_fire && tx_id == cno_cob(CNO_FC_EMCY, node_id)) begin
         emcy_pend <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         boot_pend <= 1'b0;
      end else if (state == CNO_RST_COMM && next_state == CNO_PREOP) begin
         boot_pend <= 1'b1;
      end else if (tx_fire && tx_data[7:0] == CNO_HB_BOOT && tx_id == cno_cob(CNO_FC_HB, node_id)) begin
         boot_pend <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || hb_prod_ms == '0 || boot_en) begin
         hb_age  <= '0;
         hb_pend <= 1'b0;
      end else if (tick && hb_age + 1'b1 >= hb_prod_ms) begin
         hb_age  <= '0;
         hb_pend <= 1'b1;
      end else begin
         if (tick) begin
            hb_age <= hb_age + 1'b1;
         end
         if (tx_fire && !boot_pend && !(emcy_pend && emcy_en)) begin
            hb_pend <= 1'b0;
         end
      end
   end

   // transmit selection, boot then emergency then heartbeat
   always_comb begin
      tx_valid = 1'b0;
      tx_id    = cno_cob(CNO_FC_HB, node_id);
      tx_dlc   = CNO_HB_DLC;
      tx_data  = '0;
      if (boot_pend) begin
         tx_valid = 1'b1;
         tx_data[7:0] = CNO_HB_BOOT;
      end else if (emcy_pend && emcy_en) begin
         tx_valid = 1'b1;
         tx_id    = cno_cob(CNO_FC_EMCY, node_id);
         tx_dlc   = CNO_EMCY_DLC;
         tx_data  = {emcy_is_clear ? CNO_MAKER_NONE : fault_maker, err_reg,
                     emcy_is_clear ? CNO_EC_CLEAR : fault_code};
      end else if (hb_pend) begin
         tx_valid = 1'b1;
         tx_data[7:0] = state == CNO_STOP ? CNO_HB_STOP : state == CNO_OP ? CNO_HB_OP : CNO_HB_PREOP;
      end
   end
   assign tx_fire = tx_valid && tx_ready;

   assign cob_tpdo1  = cno_cob(CNO_FC_TPDO1, node_id);
   assign cob_rpdo1  = cno_cob(CNO_FC_RPDO1, node_id);
   assign cob_sdo_tx = cno_cob(CNO_FC_SDO_TX, node_id);
   assign cob_sdo_rx = cno_cob(CNO_FC_SDO_RX, node_id);

   property p_reset_init;
      @(posedge clk) rst |=> state == CNO_RST_APP;
   endproperty
   a_reset_init: assert property (p_reset_init) else $error("reset did not enter init");
   property p_boot;
      @(posedge clk) disable iff (rst) state == CNO_RST_COMM && comm_done |=> state == CNO_PREOP && boot_pend;
   endproperty
   a_boot: assert property (p_boot) else $error("no boot-up after init");
   property p_gate;
      @(posedge clk) disable iff (rst) pdo_en |-> sdo_en && nmt_en && !boot_en;
   endproperty
   a_gate: assert property (p_gate) else $error("gating wrong");
   property p_start;
      @(posedge clk) disable iff (rst)
         cmd_hit && !sync_mode && rx_b0 == CNO_CS_START |=> state == CNO_OP;
   endproperty
   a_start: assert property (p_start) else $error("start ignored");
   property p_defer;
      @(posedge clk) disable iff (rst)
         pend && !sync_pulse && sync_mode && nmt_en |=> $stable(state);
   endproperty
   a_defer: assert property (p_defer) else $error("command not deferred");
   property p_fault;
      @(posedge clk) disable iff (rst) $rose(fault) |=> ##1 in_error && err_reg != CNO_ER_NONE;
   endproperty
   a_fault: assert property (p_fault) else $error("fault not flagged");
   property p_emcy;
      @(posedge clk) disable iff (rst)
         tx_valid && tx_dlc == CNO_EMCY_DLC |-> tx_id == {CNO_FC_EMCY, node_id} && tx_data[23:16] == err_reg;
   endproperty
   a_emcy: assert property (p_emcy) else $error("emergency frame bad");
   // no answer frame to a command
   property p_noack;
      @(posedge clk) disable iff (rst) tx_valid |-> tx_id != CNO_ID_NMT;
   endproperty
   a_noack: assert property (p_noack) else $error("command acknowledged");

   c_op: cover property (@(posedge clk) state == CNO_OP);
   c_emcy: cover property (@(posedge clk) tx_fire && tx_dlc == CNO_EMCY_DLC);
   c_lost: cover property (@(posedge clk) hb_lost);
endmodule : cno_nmt_node
`default_nettype wire

// ==== logic/cno_pkg.sv ====
package cno_pkg;
   // node states, gray coded along init -> preop -> op -> stop
   typedef enum logic [2:0] {
      CNO_RST_APP  = 3'b000,
      CNO_RST_COMM = 3'b001,
      CNO_PREOP    = 3'b011,
      CNO_OP       = 3'b010,
      CNO_STOP     = 3'b110
   } cno_state_t;

   localparam logic [3:0]  CNO_FC_NMT     = 4'h0;
   localparam logic [3:0]  CNO_FC_SYNC    = 4'h1;
   localparam logic [3:0]  CNO_FC_TIME    = 4'h2;
   localparam logic [3:0]  CNO_FC_EMCY    = 4'h1;
   localparam logic [3:0]  CNO_FC_TPDO1   = 4'h3;
   localparam logic [3:0]  CNO_FC_RPDO1   = 4'h4;
   localparam logic [3:0]  CNO_FC_SDO_TX  = 4'hb;
   localparam logic [3:0]  CNO_FC_SDO_RX  = 4'hc;
   localparam logic [3:0]  CNO_FC_HB      = 4'he;
   localparam logic [10:0] CNO_ID_NMT     = 11'h000;
   localparam logic [10:0] CNO_ID_SYNC    = 11'h080;
   localparam logic [10:0] CNO_ID_TIME    = 11'h100;
   localparam logic [6:0]  CNO_NODE_BCAST = 7'h00;

   localparam logic [7:0]  CNO_CS_START   = 8'h01;
   localparam logic [7:0]  CNO_CS_STOP    = 8'h02;
   localparam logic [7:0]  CNO_CS_PREOP   = 8'h80;
   localparam logic [7:0]  CNO_CS_RST_APP = 8'h81;
   localparam logic [7:0]  CNO_CS_RST_COM = 8'h82;
   localparam logic [3:0]  CNO_NMT_DLC    = 4'h2;

   localparam logic [7:0]  CNO_ER_NONE    = 8'h00;
   localparam logic [7:0]  CNO_ER_GENERIC = 8'h01;
   localparam logic [7:0]  CNO_ER_DEVICE  = 8'h80;
   localparam logic [15:0] CNO_EC_CLEAR   = 16'h0000;
   localparam logic [15:0] CNO_IDX_ERRREG = 16'h1001;
   localparam logic [3:0]  CNO_EMCY_DLC   = 4'h8;
   localparam logic [3:0]  CNO_HB_DLC     = 4'h1;
   localparam logic [7:0]  CNO_HB_BOOT    = 8'h00;
   localparam logic [7:0]  CNO_HB_STOP    = 8'h04;
   localparam logic [7:0]  CNO_HB_OP      = 8'h05;
   localparam logic [7:0]  CNO_HB_PREOP   = 8'h7f;
   localparam logic [39:0] CNO_MAKER_NONE = 40'h0;

   localparam int          CNO_CLK_HZ     = 20_000_000;
   localparam int          CNO_TICK_US    = 1000;
   localparam int          CNO_TICK_CYC   = CNO_CLK_HZ / 1_000_000 * CNO_TICK_US;

   // identifier = function code over node address
   function automatic logic [10:0] cno_cob(input logic [3:0] fc, input logic [6:0] node);
      cno_cob = {fc, node};
   endfunction : cno_cob
endpackage : cno_pkg

// ==== logic/cno_ms_tick.sv ====
`timescale 1ns/1ps
`default_nettype none
module cno_ms_tick
   import cno_pkg::*;
#(
   parameter int TICK_CYC = CNO_TICK_CYC
) (
   input  wire logic clk,   // core clock
   input  wire logic rst,   // sync reset
   output logic      tick   // one pulse per millisecond
);
   logic [$clog2(TICK_CYC)-1:0] cnt;

   always_ff @(posedge clk) begin
      if (rst || cnt == ($clog2(TICK_CYC))'(TICK_CYC - 1)) begin
         cnt <= '0;
      end else begin
         cnt <= cnt + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      tick <= !rst && cnt == ($clog2(TICK_CYC))'(TICK_CYC - 1);
   end
endmodule : cno_ms_tick
`default_nettype wire

// ==== logic/cno_hb_consumer.sv ====
`timescale 1ns/1ps
`default_nettype none
module cno_hb_consumer
   import cno_pkg::*;
(
   input  wire logic        clk,        // core clock
   input  wire logic        rst,        // sync reset
   input  wire logic        tick,       // millisecond tick
   input  wire logic [15:0] timeout_ms, // 0 disables monitoring
   input  wire logic        hb_seen,    // heartbeat from producer
   output logic             lost        // sticky until next heartbeat
);
   logic [15:0] age;

   always_ff @(posedge clk) begin
      if (rst || hb_seen || timeout_ms == '0) begin
         age  <= '0;
         lost <= 1'b0;
      end else if (tick && !lost) begin
         age <= age + 1'b1;
         if (age + 1'b1 >= timeout_ms) begin
            lost <= 1'b1;
         end
      end
   end
endmodule : cno_hb_consumer
`default_nettype wire

// ==== tb/cno_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cno_master_model
   import cno_pkg::*;
(
   input  wire logic        clk,      // core clock
   input  wire logic        slow,     // stall the node's frames
   input  wire logic        tx_valid, // node offers a frame
   input  wire logic [10:0] tx_id,    // offered identifier
   input  wire logic [3:0]  tx_dlc,   // offered length
   input  wire logic [63:0] tx_data,  // offered payload
   output logic             tx_ready, // frame taken
   output logic             rx_valid, // frame strobe to node
   output logic [10:0]      rx_id,    // identifier to node
   output logic [3:0]       rx_dlc,   // length to node
   output logic [7:0]       rx_b0,    // byte 0 to node
   output logic [7:0]       rx_b1     // byte 1 to node
);
   int          frames = 0;
   logic [1:0]  stall  = 2'h0;
   logic [10:0] last_id;
   logic [3:0]  last_dlc;
   logic [63:0] last_data;
   logic [511:0] request_staging_area;

   initial begin
      rx_valid = 1'b0;
      rx_id    = 11'h7ff;
      rx_dlc   = 4'hf;
      rx_b0    = 8'h5a;
      rx_b1    = 8'ha5;
   end

   // slow mode takes one cycle in four, like a busy bus
   assign tx_ready = !slow || (stall == 2'h3);

   always @(posedge clk) begin
      stall <= stall + 2'h1;
      if (tx_valid === 1'b1 && tx_ready) begin
         frames    <= frames + 1;
         last_id   <= tx_id;
         last_dlc  <= tx_dlc;
         last_data <= tx_data;
      end
   end

   task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [7:0] b0, input logic [7:0] b1);
      request_staging_area = '0;
      request_staging_area[15:0] = {b1, b0};
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_id    <= id;
      rx_dlc   <= dlc;
      rx_b0    <= request_staging_area[7:0];
      rx_b1    <= request_staging_area[15:8];
      @(posedge clk);
      // idle bus shows no stale frame
      rx_valid <= 1'b0;
      rx_id    <= ~id;
      rx_dlc   <= ~dlc;
      rx_b0    <= ~b0;
      rx_b1    <= ~b1;
   endtask : send
endmodule : cno_master_model
`default_nettype wire

// ==== tb/test_canopen_nmt_node_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_canopen_nmt_node_control
   import cno_pkg::*;
();
   localparam logic [10:0] N11 = 11'h00a;
   typedef struct packed {
      logic [10:0] id;
      logic [3:0]  dlc;
      logic [7:0]  cs;
      logic [7:0]  addr;
      cno_state_t  st;
   } cno_row_t;
   // last row: a guarding poll on the own error-control id must get no answer
   cno_row_t rows [12] = '{
      '{11'h000, 4'h2, 8'h01, 8'h0a, CNO_OP},    '{11'h000, 4'h2, 8'h80, 8'h00, CNO_PREOP},
      '{11'h000, 4'h2, 8'h02, 8'h0a, CNO_STOP},  '{11'h000, 4'h2, 8'h01, 8'h0b, CNO_STOP},
      '{11'h000, 4'h2, 8'h80, 8'h0a, CNO_PREOP}, '{11'h000, 4'h2, 8'h03, 8'h0a, CNO_PREOP},
      '{11'h000, 4'h3, 8'h01, 8'h0a, CNO_PREOP}, '{11'h000, 4'h2, 8'h01, 8'h8a, CNO_PREOP},
      '{11'h001, 4'h2, 8'h01, 8'h0a, CNO_PREOP}, '{11'h000, 4'h2, 8'h02, 8'h00, CNO_STOP},
      '{11'h000, 4'h2, 8'h01, 8'h00, CNO_OP},    '{11'h70a, 4'h0, 8'h00, 8'h00, CNO_OP}};
   logic        clk = 1'b0, rst = 1'b1, app_done = 1'b0, comm_done = 1'b0, slow = 1'b0;
   logic        sync_mode = 1'b0, fault = 1'b0, fault_dev = 1'b0;
   logic [15:0] hb_prod_ms = 16'h0, hb_cons_ms = 16'h0, fault_code = 16'h0;
   logic [6:0]  node_id = 7'h0a, hb_cons_node = 7'h05;
   logic [39:0] fault_maker = 40'h0;
   logic        rx_valid, tx_ready, tx_valid, pdo_en, sdo_en, sync_en, time_en, emcy_en, boot_en, nmt_en;
   logic        sync_pulse, app_rst_req, comm_rst_req, in_error, hb_lost;
   logic [10:0] rx_id, tx_id, cob_tpdo1, cob_rpdo1, cob_sdo_tx, cob_sdo_rx;
   logic [3:0]  rx_dlc, tx_dlc;
   logic [7:0]  rx_b0, rx_b1, err_reg;
   logic [63:0] tx_data;
   cno_state_t  state;
   int          fail_count = 0, total_checks = 0, syncs = 0, apps = 0, comms = 0, n, a0, c0;

   cno_nmt_node #(.TICK_CYC(10)) dut_u (
      .clk(clk), .rst(rst), .node_id(node_id), .rx_valid(rx_valid), .rx_id(rx_id), .rx_dlc(rx_dlc),
      .rx_b0(rx_b0), .rx_b1(rx_b1), .app_done(app_done), .comm_done(comm_done), .sync_mode(sync_mode),
      .hb_prod_ms(hb_prod_ms), .hb_cons_ms(hb_cons_ms), .hb_cons_node(hb_cons_node), .fault(fault),
      .fault_dev(fault_dev), .fault_code(fault_code), .fault_maker(fault_maker), .tx_ready(tx_ready),
      .tx_valid(tx_valid), .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data), .state(state), .pdo_en(pdo_en),
      .sdo_en(sdo_en), .sync_en(sync_en), .time_en(time_en), .emcy_en(emcy_en), .boot_en(boot_en),
      .nmt_en(nmt_en), .sync_pulse(sync_pulse), .app_rst_req(app_rst_req), .comm_rst_req(comm_rst_req),
      .in_error(in_error), .err_reg(err_reg), .hb_lost(hb_lost), .cob_tpdo1(cob_tpdo1),
      .cob_rpdo1(cob_rpdo1), .cob_sdo_tx(cob_sdo_tx), .cob_sdo_rx(cob_sdo_rx));

   cno_master_model u_master (
      .clk(clk), .slow(slow), .tx_valid(tx_valid), .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data),
      .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_b0(rx_b0), .rx_b1(rx_b1));

   always #25 clk = ~clk;

   always @(posedge clk) begin
      if (sync_pulse === 1'b1)
         syncs <= syncs + 1;
      if (app_rst_req === 1'b1)
         apps <= apps + 1;
      if (comm_rst_req === 1'b1)
         comms <= comms + 1;
   end

   task automatic chk_val(input logic [63:0] got, input logic [63:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk_val

   task automatic chk_state(input cno_state_t exp);
      total_checks++;
      if (state !== exp) begin
         fail_count++;
         $display("mismatch at %0t: state got %b exp %b", $time, state, exp);
      end
   endtask : chk_state

   task automatic chk_gates(input cno_state_t st);
      logic po;
      po = (st == CNO_PREOP) || (st == CNO_OP);
      chk_val(pdo_en, st == CNO_OP, "pdo gate");
      chk_val({sdo_en, sync_en, time_en, emcy_en}, {4{po}}, "preop gates");
      chk_val(boot_en, st == CNO_RST_APP || st == CNO_RST_COMM, "boot gate");
      chk_val(nmt_en, po || st == CNO_STOP, "nmt gate");
   endtask : chk_gates

   // bytes beyond the length carry nothing, so they are masked off
   task automatic chk_frame(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] data);
      logic [63:0] m;
      m = (dlc >= 4'h8) ? '1 : ((64'h1 << (8 * dlc)) - 64'h1);
      chk_val(u_master.last_id, id, "frame id");
      chk_val(u_master.last_dlc, dlc, "frame dlc");
      chk_val(u_master.last_data & m, data, "frame data");
   endtask : chk_frame

   task automatic settle(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : settle

   task automatic wait_frame(input int k);
      for (int i = 0; i < 400 && u_master.frames < k; i++)
         @(posedge clk);
      #1;
   endtask : wait_frame

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : results

   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      results();
   end

   initial begin
      logic [7:0]  er;
      logic [15:0] code;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      settle(3);
      chk_state(CNO_RST_APP);
      chk_val({app_rst_req, comm_rst_req, tx_valid}, 3'h4, "init outputs");
      chk_gates(CNO_RST_APP);
      chk_val(err_reg, 8'h00, "reset error reg");
      chk_val({cob_tpdo1, cob_rpdo1, cob_sdo_tx, cob_sdo_rx},
              {11'h180 + N11, 11'h200 + N11, 11'h580 + N11, 11'h600 + N11}, "cob ids");
      @(posedge clk) app_done <= 1'b1;
      settle(2);
      chk_state(CNO_RST_COMM);
      @(posedge clk) comm_done <= 1'b1;
      wait_frame(1);
      chk_state(CNO_PREOP);
      chk_frame(11'h700 + N11, CNO_HB_DLC, 64'h0);
      $display("test boot finished");
      for (int i = 0; i < 12; i++) begin
         n = u_master.frames;
         u_master.send(rows[i].id, rows[i].dlc, rows[i].cs, rows[i].addr);
         settle(2);
         chk_state(rows[i].st);
         chk_gates(rows[i].st);
         chk_val(u_master.frames, n, "reply frame");
      end
      $display("test command table finished");
      @(posedge clk) sync_mode <= 1'b1;
      n = syncs;
      u_master.send(11'h000, 4'h2, 8'h02, 8'h0a);
      settle(3);
      chk_state(CNO_OP);
      u_master.send(11'h080, 4'h0, 8'h00, 8'h00);
      settle(2);
      chk_state(CNO_STOP);
      u_master.send(11'h080, 4'h0, 8'h00, 8'h00);
      settle(2);
      chk_val(syncs, n + 1, "sync pulses");
      @(posedge clk) sync_mode <= 1'b0;
      u_master.send(11'h000, 4'h2, 8'h01, 8'h0a);
      settle(2);
      chk_state(CNO_OP);
      $display("test sync finished");
      @(posedge clk) slow <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         er = (i == 0) ? 8'h80 : 8'h01;
         code = (i == 0) ? 16'h1234 : 16'hff01;
         n = u_master.frames;
         @(posedge clk);
         fault_dev   <= (i == 0);
         fault_code  <= code;
         fault_maker <= 40'h0504030201;
         fault       <= 1'b1;
         wait_frame(n + 1);
         chk_frame(11'h080 + N11, 4'h8, {40'h0504030201, er, code});
         chk_val({in_error, err_reg}, {1'b1, er}, "error state");
         @(posedge clk) fault <= 1'b0;
         wait_frame(n + 2);
         chk_frame(11'h080 + N11, 4'h8, 64'h0);
         chk_val({in_error, err_reg}, 9'h0, "error cleared");
      end
      $display("test emergency finished");
      @(posedge clk);
      slow       <= 1'b0;
      hb_prod_ms <= 16'h2;
      settle(5);
      n = u_master.frames;
      settle(200);
      chk_val((u_master.frames - n) inside {[9:11]}, 1'b1, "heartbeat count");
      chk_frame(11'h700 + N11, CNO_HB_DLC, 64'h05);
      @(posedge clk) hb_prod_ms <= 16'h0;
      settle(30);
      n = u_master.frames;
      settle(100);
      chk_val(u_master.frames, n, "heartbeat off");
      @(posedge clk) hb_cons_ms <= 16'h3;
      u_master.send(11'h705, 4'h1, 8'h7f, 8'h00);
      settle(10);
      chk_val(hb_lost, 1'b0, "consumer alive");
      u_master.send(11'h706, 4'h1, 8'h7f, 8'h00);
      settle(50);
      chk_val(hb_lost, 1'b1, "consumer lost");
      u_master.send(11'h705, 4'h1, 8'h7f, 8'h00);
      settle(2);
      chk_val(hb_lost, 1'b0, "consumer back");
      $display("test heartbeat finished");
      for (int i = 0; i < 2; i++) begin
         n = u_master.frames;
         a0 = apps;
         c0 = comms;
         u_master.send(11'h000, 4'h2, (i == 0) ? 8'h81 : 8'h82, 8'h0a);
         wait_frame(n + 1);
         chk_val({apps > a0, comms > c0}, {i == 0, 1'b1}, "reset path");
         chk_state(CNO_PREOP);
         chk_frame(11'h700 + N11, CNO_HB_DLC, 64'h0);
      end
      $display("test remote reset finished");
      results();
   end
endmodule : test_canopen_nmt_node_control
`default_nettype wire
